// *** rtl/dtc_consts.vh ***
// Constants for the display tuning configuration register block
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// ----------------------------------------------------------------
// Register map (byte addresses on the Avalon-MM slave)
// ----------------------------------------------------------------
`define DTC_ADDR_LOW        4'h0
`define DTC_ADDR_HIGH       4'h4
`define DTC_ADDR_STATUS     4'h8

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DTC_RED_PDC_LSB     0
`define DTC_GRN_PDC_LSB     4
`define DTC_BLU_PDC_LSB     8
`define DTC_RED_DCP_LSB     12
`define DTC_GRN_DCP_LSB     16
`define DTC_BLU_DCP_LSB     20
`define DTC_RED_LGC_LSB     24
`define DTC_GRN_LGC_LSB     28
`define DTC_BLU_LGC_LSB     32
`define DTC_RED_IMM_BIT     39
`define DTC_GRN_IMM_BIT     40
`define DTC_BLU_IMM_BIT     41
`define DTC_SUBP_BIT        42
`define DTC_GEOM_LSB        43
`define DTC_PSAVE_BIT       47

`define DTC_PDC_RESET       4'h6
`define DTC_DCP_RESET       4'h0
`define DTC_LGC_RESET       4'h0
`define DTC_IMM_RESET       1'h1
`define DTC_SUBP_RESET      1'h0
`define DTC_GEOM_RESET      3'h7
`define DTC_PSAVE_RESET     1'h0

// Writable bits: all except 46 and 38:36
`define DTC_WRITE_MASK      48'hbf8f_ffff_ffff
`define DTC_RESET_VALUE     48'h3b80_0000_0666

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DTC_READ_WAIT       1

`endif

// *** rtl/dtc_field_decode.v ***
// Decoder of tuning fields into drive levels for the analog side
`timescale 1ns/1ps
`include "dtc_consts.vh"
module dtc_field_decode (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst,
	// Stored register image
	input  wire [47:0] cfg_value,
	// Pre-discharge voltages in 0.1 V units
	output reg  [4:0]  red_pdc_mv100,
	output reg  [4:0]  green_pdc_mv100,
	output reg  [4:0]  blue_pdc_mv100,
	// Panel geometry: pixel rows/columns and scan order
	output reg  [6:0]  panel_pixels,
	output reg  [1:0]  panel_reversed_lines,
	output reg         panel_swap_order
);

	// ----------------------------------------------------------------
	// Code to voltage
	// ----------------------------------------------------------------
	// Linear 0.1 V steps up to 1010b, then 0.2 V steps from 1.3 V
	function [4:0] pdc_volts;
		input [3:0] code;
		begin
			if (code <= 4'ha) begin
				pdc_volts = {1'b0, code} + 5'h01;
			end else begin
				pdc_volts = 5'h0d + {code - 4'hb, 1'b0};
			end
		end
	endfunction

	wire [2:0] geom_code;
	assign geom_code = cfg_value[`DTC_GEOM_LSB +: 3];

	always @(posedge ref_clk) begin
		if (rst) begin
			red_pdc_mv100        <= 5'h07;
			green_pdc_mv100      <= 5'h07;
			blue_pdc_mv100       <= 5'h07;
			panel_pixels         <= 7'h40;
			panel_reversed_lines <= 2'h2;
			panel_swap_order     <= 1'b0;
		end else begin
			red_pdc_mv100   <= pdc_volts(cfg_value[`DTC_RED_PDC_LSB +: 4]);
			green_pdc_mv100 <= pdc_volts(cfg_value[`DTC_GRN_PDC_LSB +: 4]);
			blue_pdc_mv100  <= pdc_volts(cfg_value[`DTC_BLU_PDC_LSB +: 4]);
			case (geom_code)
				3'h0: begin
					panel_pixels         <= 7'h10;
					panel_reversed_lines <= 2'h0;
					panel_swap_order     <= 1'b0;
				end
				3'h1: begin
					panel_pixels         <= 7'h20;
					panel_reversed_lines <= 2'h0;
					panel_swap_order     <= 1'b0;
				end
				3'h2, 3'h3: begin
					panel_pixels         <= 7'h30;
					panel_reversed_lines <= 2'h1;
					panel_swap_order     <= geom_code[0];
				end
				3'h4, 3'h5: begin
					panel_pixels         <= 7'h30;
					panel_reversed_lines <= 2'h2;
					panel_swap_order     <= geom_code[0];
				end
				default: begin
					panel_pixels         <= 7'h40;
					panel_reversed_lines <= 2'h2;
					panel_swap_order     <= 1'b0;
				end
			endcase
		end
	end

endmodule

// *** rtl/dtc_tuning_regs.v ***
// Display tuning configuration register with Avalon-MM slave
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "dtc_consts.vh"
module dtc_tuning_regs (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst,
	// Avalon-MM slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	output reg  [1:0]  avs_response,
	// Raw tuning fields
	output reg  [3:0]  red_predischarge_code,
	output reg  [3:0]  green_predischarge_code,
	output reg  [3:0]  blue_predischarge_code,
	output reg  [3:0]  red_decoupling_level,
	output reg  [3:0]  green_decoupling_level,
	output reg  [3:0]  blue_decoupling_level,
	output reg  [3:0]  red_lowgray_compensation,
	output reg  [3:0]  green_lowgray_compensation,
	output reg  [3:0]  blue_lowgray_compensation,
	output reg         red_group_noise_immunity,
	output reg         green_group_noise_immunity,
	output reg         blue_group_noise_immunity,
	output reg         subperiod_limit_enable,
	output reg  [2:0]  panel_geometry_select,
	output reg         power_saving_enable,
	// Decoded levels
	output wire [4:0]  red_pdc_mv100,
	output wire [4:0]  green_pdc_mv100,
	output wire [4:0]  blue_pdc_mv100,
	output wire [6:0]  panel_pixels,
	output wire [1:0]  panel_reversed_lines,
	output wire        panel_swap_order
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	reg  [47:0] cfg_reg;
	reg  [47:0] cfg_next;
	reg         ack_reg;
	reg  [31:0] rdata_next;
	reg  [1:0]  resp_next;
	reg  [15:0] write_count_reg;
	reg  [31:0] hi_merge;

	wire        req;
	wire        hit_low;
	wire        hit_high;
	wire        hit_status;
	assign req        = avs_read | avs_write;
	assign hit_low    = (avs_address == `DTC_ADDR_LOW);
	assign hit_high   = (avs_address == `DTC_ADDR_HIGH);
	assign hit_status = (avs_address == `DTC_ADDR_STATUS);

	// Merges byte lanes of a write into a 32-bit word
	function [31:0] lane_merge;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0]  lanes;
		integer      i;
		begin
			lane_merge = old_word;
			for (i = 0; i < 4; i = i + 1) begin
				if (lanes[i]) begin
					lane_merge[i*8 +: 8] = new_word[i*8 +: 8];
				end
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Write path
	// ----------------------------------------------------------------
	// Reserved bits are masked so they always read zero
	always @* begin
		hi_merge = lane_merge({16'h0000, cfg_reg[47:32]}, avs_writedata, avs_byteenable);
		cfg_next = cfg_reg;
		if (avs_write && ack_reg) begin
			if (hit_low) begin
				cfg_next[31:0] = lane_merge(cfg_reg[31:0], avs_writedata,
					avs_byteenable);
			end else if (hit_high) begin
				// Lanes 2 and 3 fall outside the 48-bit image and are dropped
				cfg_next[47:32] = hi_merge[15:0];
			end
		end
		cfg_next = cfg_next & `DTC_WRITE_MASK;
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always @* begin
		rdata_next = 32'h0000_0000;
		resp_next  = 2'h0;
		if (hit_low) begin
			rdata_next = cfg_reg[31:0];
		end else if (hit_high) begin
			rdata_next = {16'h0000, cfg_reg[47:32]};
		end else if (hit_status) begin
			rdata_next = {16'h0000, write_count_reg};
		end else begin
			resp_next = 2'h2;
		end
	end

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// One wait state per access: waitrequest drops the cycle after the
	// request appears, so every transfer completes in exactly two cycles.
	always @(posedge ref_clk) begin
		if (rst) begin
			cfg_reg         <= `DTC_RESET_VALUE;
			ack_reg         <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			avs_response    <= 2'h0;
			write_count_reg <= 16'h0000;
		end else begin
			cfg_reg <= cfg_next;
			if (req && !ack_reg) begin
				ack_reg         <= 1'b1;
				avs_waitrequest <= 1'b0;
				avs_readdata    <= avs_read ? rdata_next : 32'h0000_0000;
				avs_response    <= resp_next;
			end else begin
				ack_reg         <= 1'b0;
				avs_waitrequest <= 1'b1;
			end
			if (avs_write && ack_reg && (hit_low || hit_high)) begin
				write_count_reg <= write_count_reg + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Field outputs
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (rst) begin
			red_predischarge_code      <= `DTC_PDC_RESET;
			green_predischarge_code    <= `DTC_PDC_RESET;
			blue_predischarge_code     <= `DTC_PDC_RESET;
			red_decoupling_level       <= `DTC_DCP_RESET;
			green_decoupling_level     <= `DTC_DCP_RESET;
			blue_decoupling_level      <= `DTC_DCP_RESET;
			red_lowgray_compensation   <= `DTC_LGC_RESET;
			green_lowgray_compensation <= `DTC_LGC_RESET;
			blue_lowgray_compensation  <= `DTC_LGC_RESET;
			red_group_noise_immunity   <= `DTC_IMM_RESET;
			green_group_noise_immunity <= `DTC_IMM_RESET;
			blue_group_noise_immunity  <= `DTC_IMM_RESET;
			subperiod_limit_enable     <= `DTC_SUBP_RESET;
			panel_geometry_select      <= `DTC_GEOM_RESET;
			power_saving_enable        <= `DTC_PSAVE_RESET;
		end else begin
			red_predischarge_code      <= cfg_next[`DTC_RED_PDC_LSB +: 4];
			green_predischarge_code    <= cfg_next[`DTC_GRN_PDC_LSB +: 4];
			blue_predischarge_code     <= cfg_next[`DTC_BLU_PDC_LSB +: 4];
			red_decoupling_level       <= cfg_next[`DTC_RED_DCP_LSB +: 4];
			green_decoupling_level     <= cfg_next[`DTC_GRN_DCP_LSB +: 4];
			blue_decoupling_level      <= cfg_next[`DTC_BLU_DCP_LSB +: 4];
			red_lowgray_compensation   <= cfg_next[`DTC_RED_LGC_LSB +: 4];
			green_lowgray_compensation <= cfg_next[`DTC_GRN_LGC_LSB +: 4];
			blue_lowgray_compensation  <= cfg_next[`DTC_BLU_LGC_LSB +: 4];
			red_group_noise_immunity   <= cfg_next[`DTC_RED_IMM_BIT];
			green_group_noise_immunity <= cfg_next[`DTC_GRN_IMM_BIT];
			blue_group_noise_immunity  <= cfg_next[`DTC_BLU_IMM_BIT];
			subperiod_limit_enable     <= cfg_next[`DTC_SUBP_BIT];
			panel_geometry_select      <= cfg_next[`DTC_GEOM_LSB +: 3];
			power_saving_enable        <= cfg_next[`DTC_PSAVE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Decoders
	// ----------------------------------------------------------------
	// Decoded levels lag the raw fields by one cycle since they
	// are registered from the stored image, not from cfg_next.
	dtc_field_decode u_decode (
		.ref_clk              (ref_clk),
		.rst                  (rst),
		.cfg_value            (cfg_reg),
		.red_pdc_mv100        (red_pdc_mv100),
		.green_pdc_mv100      (green_pdc_mv100),
		.blue_pdc_mv100       (blue_pdc_mv100),
		.panel_pixels         (panel_pixels),
		.panel_reversed_lines (panel_reversed_lines),
		.panel_swap_order     (panel_swap_order)
	);

endmodule

// *** testbench/dtc_tuning_regs_assertions.sv ***
// Concurrent checks on the tuning register ports
`timescale 1ns/1ps
module dtc_tuning_regs_chk (
	// Clock and reset
	input wire        ref_clk,
	input wire        rst,
	// Bus
	input wire [3:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire [1:0]  avs_response,
	// Fields
	input wire [3:0]  red_predischarge_code,
	input wire [3:0]  green_predischarge_code,
	input wire        red_group_noise_immunity,
	input wire        subperiod_limit_enable,
	input wire [2:0]  panel_geometry_select,
	input wire        power_saving_enable,
	input wire [4:0]  red_pdc_mv100
);
	wire rd_done = avs_read && !avs_waitrequest;
	wire wr_done = avs_write && !avs_waitrequest;
	wire mapped  = avs_address == 4'h0 || avs_address == 4'h4 || avs_address == 4'h8;

	function [4:0] volt(input [3:0] c);
		volt = (c <= 4'ha) ? {1'b0, c} + 5'h1 : {c, 1'b0} - 5'h9;
	endfunction

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low twice");
	a_wait_answer: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer after one wait state");
	a_resp_code: assert property (
		(rd_done || wr_done) |-> avs_response == (mapped ? 2'b00 : 2'b10))
		else $error("wrong response code");
	a_reserved_zero: assert property (
		rd_done && avs_address == 4'h4 |->
		avs_readdata[31:16] == 16'h0 && avs_readdata[14] == 1'b0 && avs_readdata[6:4] == 3'h0)
		else $error("reserved bits not zero");
	a_read_low: assert property (
		rd_done && avs_address == 4'h0 |->
		avs_readdata[7:0] == {green_predischarge_code, red_predischarge_code})
		else $error("low word read mismatch");
	a_write_pdc: assert property (
		wr_done && avs_address == 4'h0 && avs_byteenable[0] |=>
		red_predischarge_code == $past(avs_writedata[3:0]))
		else $error("red code not written");
	a_write_top: assert property (
		wr_done && avs_address == 4'h4 && avs_byteenable[1] |=>
		power_saving_enable == $past(avs_writedata[15]) &&
		{panel_geometry_select, subperiod_limit_enable} == $past(avs_writedata[13:10]))
		else $error("upper fields not written");
	a_pdc_map: assert property (red_pdc_mv100 == volt($past(red_predischarge_code)))
		else $error("voltage decode wrong");
	a_reset_vals: assert property (disable iff (1'b0) rst |=>
		red_predischarge_code == 4'h6 && red_group_noise_immunity == 1'b1 &&
		panel_geometry_select == 3'h7 && subperiod_limit_enable == 1'b0 &&
		power_saving_enable == 1'b0)
		else $error("reset values wrong");
endmodule

// *** testbench/tb.sv ***
// Self-checking testbench for the tuning configuration register
`timescale 1ns/1ps
`include "dtc_consts.vh"
module tb;
	reg         ref_clk = 1'b0;
	reg         rst = 1'b1;
	reg  [3:0]  avs_address = 4'h0;
	reg         avs_read = 1'b0;
	reg         avs_write = 1'b0;
	reg  [31:0] avs_writedata = 32'h0;
	reg  [3:0]  avs_byteenable = 4'h0;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire [1:0]  avs_response;
	wire [3:0]  red_predischarge_code, green_predischarge_code, blue_predischarge_code;
	wire [3:0]  red_decoupling_level, green_decoupling_level, blue_decoupling_level;
	wire [3:0]  red_lowgray_compensation, green_lowgray_compensation, blue_lowgray_compensation;
	wire        red_group_noise_immunity, green_group_noise_immunity, blue_group_noise_immunity;
	wire        subperiod_limit_enable, power_saving_enable, panel_swap_order;
	wire [2:0]  panel_geometry_select;
	wire [4:0]  red_pdc_mv100, green_pdc_mv100, blue_pdc_mv100;
	wire [6:0]  panel_pixels;
	wire [1:0]  panel_reversed_lines;
	reg  [47:0] sh;
	reg  [15:0] nwr;
	reg  [31:0] rd;
	reg  [3:0]  a, be;
	integer     n_fail = 0, n_checks = 0, i;
	wire [47:0] fld = {power_saving_enable, 1'b0, panel_geometry_select, subperiod_limit_enable,
		blue_group_noise_immunity, green_group_noise_immunity, red_group_noise_immunity, 3'h0,
		blue_lowgray_compensation, green_lowgray_compensation, red_lowgray_compensation,
		blue_decoupling_level, green_decoupling_level, red_decoupling_level,
		blue_predischarge_code, green_predischarge_code, red_predischarge_code};

	always #50 ref_clk = ~ref_clk;

	dtc_tuning_regs u_dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
		.red_predischarge_code, .green_predischarge_code, .blue_predischarge_code,
		.red_decoupling_level, .green_decoupling_level, .blue_decoupling_level,
		.red_lowgray_compensation, .green_lowgray_compensation, .blue_lowgray_compensation,
		.red_group_noise_immunity, .green_group_noise_immunity, .blue_group_noise_immunity,
		.subperiod_limit_enable, .panel_geometry_select, .power_saving_enable,
		.red_pdc_mv100, .green_pdc_mv100, .blue_pdc_mv100,
		.panel_pixels, .panel_reversed_lines, .panel_swap_order);

	function [4:0] pdc(input [3:0] c);
		pdc = (c <= 4'ha) ? {1'b0, c} + 5'h1 : {c, 1'b0} - 5'h9;
	endfunction

	// Size code to pixels per side, reversed scan lines and swapped scan order
	function [9:0] geo(input [2:0] c);
		geo = {(c == 3'h0) ? 7'h10 : (c == 3'h1) ? 7'h20 : (c[2:1] == 2'h3) ? 7'h40 : 7'h30,
			c[2] ? 2'h2 : {1'b0, c[1]}, (c == 3'h3 || c == 3'h5)};
	endfunction

	task chk(input [63:0] g, input [63:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask

	// Master holds the request until waitrequest is seen low at an edge
	task bus(input w, input [3:0] ad, input [31:0] wd, input [3:0] ben);
		integer    k;
		reg [47:0] m;
		begin
			@(posedge ref_clk);
			avs_read <= !w;
			avs_write <= w;
			avs_address <= ad;
			avs_writedata <= wd;
			avs_byteenable <= ben;
			k = 0;
			do begin
				@(posedge ref_clk);
				k = k + 1;
			end while (avs_waitrequest !== 1'b0 && k < 50);
			if (k >= 50) n_fail = n_fail + 1;
			rd = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			chk(avs_response, (ad == 4'h0 || ad == 4'h4 || ad == 4'h8) ? 2'b00 : 2'b10);
			if (!w) chk(rd, ad == 4'h0 ? sh[31:0] : ad == 4'h4 ?
				{16'h0, sh[47:32]} : ad == 4'h8 ? {16'h0, nwr} : 32'h0);
			m = 48'h0;
			for (k = 0; k < 4; k = k + 1) if (ben[k]) m[8*k +: 8] = 8'hff;
			if (ad == 4'h4) m = {m[15:0], 32'h0};
			// Reserved bits 46 and 38:36 never take written data
			m = m & 48'hbf8f_ffff_ffff;
			if (w && (ad == 4'h0 || ad == 4'h4)) begin
				sh = (sh & ~m) | ({wd[15:0], wd} & m);
				nwr = nwr + 16'h1;
			end
		end
	endtask

	task fields;
		begin
			repeat (2) @(posedge ref_clk);
			#1;
			chk(fld, sh);
			chk({red_pdc_mv100, green_pdc_mv100, blue_pdc_mv100},
				{pdc(sh[3:0]), pdc(sh[7:4]), pdc(sh[11:8])});
			chk({panel_pixels, panel_reversed_lines, panel_swap_order}, geo(sh[45:43]));
		end
	endtask

	task do_reset;
		begin
			@(posedge ref_clk);
			rst <= 1'b1;
			repeat (2) @(posedge ref_clk);
			rst <= 1'b0;
			sh = 48'h3b80_0000_0666;
			nwr = 16'h0;
		end
	endtask

	task finish_test;
		begin
			$display("checks=%0d failures=%0d", n_checks, n_fail);
			if (n_fail == 0 && n_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	initial begin
		#2000000;
		n_fail = n_fail + 1;
		finish_test;
	end

	initial begin
		void'($urandom(50724));
		do_reset;
		fields;
		bus(1'b0, 4'h0, 32'h0, 4'hf);
		bus(1'b0, 4'h4, 32'h0, 4'hf);
		for (i = 0; i < 16; i = i + 1) begin
			bus(1'b1, 4'h0, {8{i[3:0]}}, 4'hf);
			bus(1'b1, 4'h4, {8{i[3:0]}}, 4'hf);
			fields;
		end
		bus(1'b1, 4'h4, 32'hffff_ffff, 4'hf);
		bus(1'b0, 4'h4, 32'h0, 4'hf);
		bus(1'b1, 4'h6, 32'h0, 4'hf);
		bus(1'b0, 4'h0, 32'h0, 4'hf);
		for (i = 0; i < 200; i = i + 1) begin
			a = $urandom % 16;
			if (a[1:0] != 2'h0 && $urandom % 2) a = 4'h4;
			be = $urandom;
			if (be == 4'h0) be = 4'h1;
			bus(a != 4'h8 && $urandom % 2, a, $urandom, be);
			if (i % 20 == 0) fields;
		end
		do_reset;
		fields;
		bus(1'b0, 4'h8, 32'h0, 4'hf);
		finish_test;
	end
endmodule

bind dtc_tuning_regs dtc_tuning_regs_chk u_chk (.ref_clk, .rst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
	.red_predischarge_code, .green_predischarge_code, .red_group_noise_immunity,
	.subperiod_limit_enable, .panel_geometry_select, .power_saving_enable, .red_pdc_mv100);
